// ---- design/oap_aux_port.v ----
// Purpose: Overhead auxiliary serial port, export and import sides.
// Assumes: CORE_CLK 100 MHz, well above both bus clocks; pins are synchronised.
// Notes:   Port clocks are rebuilt from synchronised bus clock edges.
//
// Function
// - Output port clock is drop bus clock divided by 2 (select high) or 4 (low).
// - Input port clock is add bus clock divided by 2 (select high) or 4 (low).
// - Rate select high means 28 slots at 6.48 MHz, low 84 slots at 19.44 MHz.
// - Output address valid is high exactly for the 12 address bit periods.
// - Output data valid is high exactly for the eight data bit periods.
// - Output side strobes, address and data change on port clock falling edge.
// - Output address names the item: O-bits, V5, J2, Z6/N2 or Z7/K4.
// - Output data carries the byte named by the address just before it.
// - Input address valid high for 12 bit periods, launched on falling edge.
// - Input address names O-bits, J2, Z6/N2 or Z7/K4; never V5.
// - Input data valid is high for the eight expected data bit periods.
// - Input data sampled from second port clock rise after data valid rises.
`timescale 1ns/1ps
`include "oap_defs.vh"

module oap_aux_port #(
    parameter CHAN_W     = 9,
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW    = 2
) (
    // Clock, reset, configuration
    input  wire                      CORE_CLK,
    input  wire                      NRST,
    input  wire                      BUS_RATE_SELECT,
    input  wire                      DROP_BUS_CLOCK,
    input  wire                      ADD_BUS_CLOCK,
    // Export items from the mapper
    input  wire                      TX_VALID,
    output wire                      TX_READY,
    input  wire [CHAN_W-1:0]         TX_CHANNEL,
    input  wire [`OAP_ITEM_BITS-1:0] TX_ITEM,
    input  wire [`OAP_DATA_BITS-1:0] TX_BYTE,
    // Import requests from the mapper
    input  wire                      RQ_VALID,
    output reg                       RQ_READY,
    input  wire [CHAN_W-1:0]         RQ_CHANNEL,
    input  wire [`OAP_ITEM_BITS-1:0] RQ_ITEM,
    // Imported bytes to the mapper
    output reg                       RX_VALID,
    output reg  [`OAP_ADDR_BITS-1:0] RX_ADDR,
    output reg  [`OAP_DATA_BITS-1:0] RX_BYTE,
    // Output auxiliary port pins
    output wire                      OUT_OVH_PORT_CLOCK,
    output reg                       OUT_OVH_ADDR_VALID,
    output reg                       OUT_OVH_ADDR_SERIAL,
    output reg                       OUT_OVH_DATA_VALID,
    output reg                       OUT_OVH_DATA_SERIAL,
    // Input auxiliary port pins
    output wire                      IN_OVH_PORT_CLOCK,
    output reg                       IN_OVH_ADDR_VALID,
    output reg                       IN_OVH_ADDR_SERIAL,
    output reg                       IN_OVH_DATA_VALID,
    input  wire                      IN_OVH_DATA_SERIAL
);
    localparam TXW      = `OAP_ADDR_BITS + `OAP_DATA_BITS;
    localparam ST_IDLE  = 4'b0001;
    localparam ST_ADDR  = 4'b0010;
    localparam ST_DATA  = 4'b0100;
    localparam ST_TAIL  = 4'b1000;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    reg        sel_s1;
    reg        sel_s2;
    reg        din_s1;
    reg        din_s2;
    wire [1:0] bus_clk_pin;
    wire [1:0] port_clk;
    wire [1:0] fall_ev;
    wire [1:0] rise_ev;

    assign bus_clk_pin = {ADD_BUS_CLOCK, DROP_BUS_CLOCK};

    always @(posedge CORE_CLK) begin
        if (!NRST) begin
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
        end else begin
            sel_s1 <= BUS_RATE_SELECT;
            sel_s2 <= sel_s1;
            din_s1 <= IN_OVH_DATA_SERIAL;
            din_s2 <= din_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port clock dividers, index 0 drop side, index 1 add side
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_div
            reg       ck_s1;
            reg       ck_s2;
            reg       ck_s3;
            reg [1:0] edges;
            reg       pclk;
            reg       pclk_q;
            reg       fall;
            reg       rise;
            wire      bus_rise;
            wire [1:0] half;

            assign bus_rise = ck_s2 && !ck_s3;
            // High select is the 28 slot bus, divide by 2; low is divide by 4
            assign half = sel_s2 ? `OAP_HALF_DIV2 : `OAP_HALF_DIV4;

            always @(posedge CORE_CLK) begin
                if (!NRST) begin
                    ck_s1 <= 1'b0;
                    ck_s2 <= 1'b0;
                    ck_s3 <= 1'b0;
                    edges <= 2'h0;
                    pclk  <= 1'b0;
                    pclk_q <= 1'b0;
                    fall  <= 1'b0;
                    rise  <= 1'b0;
                end else begin
                    ck_s1 <= bus_clk_pin[g];
                    ck_s2 <= ck_s1;
                    ck_s3 <= ck_s2;
                    pclk_q <= pclk;
                    fall  <= 1'b0;
                    rise  <= 1'b0;
                    if (bus_rise) begin
                        if (edges + 2'h1 >= half) begin
                            edges <= 2'h0;
                            pclk  <= !pclk;
                            fall  <= pclk;
                            rise  <= !pclk;
                        end else begin
                            edges <= edges + 2'h1;
                        end
                    end
                end
            end

            assign port_clk[g] = pclk_q; // Delayed to move with the pins
            assign fall_ev[g]  = fall;
            assign rise_ev[g]  = rise;
        end
    endgenerate

    assign OUT_OVH_PORT_CLOCK = port_clk[0];
    assign IN_OVH_PORT_CLOCK  = port_clk[1];

    ////////////////////////////////////////////////////////////////////////////
    // Export FIFO
    wire           f_valid;
    reg            f_ready;
    wire [TXW-1:0] f_data;

    oap_fifo #(
        .WIDTH (TXW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (CORE_CLK),
        .nrst      (NRST),
        .in_valid  (TX_VALID),
        .in_ready  (TX_READY),
        .in_data   ({TX_CHANNEL, TX_ITEM, TX_BYTE}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output side serialiser
    reg [3:0]     o_state;
    reg [TXW-1:0] o_shift;
    reg [4:0]     o_bits;

    always @(posedge CORE_CLK) begin
        if (!NRST) begin
            o_state             <= ST_IDLE;
            o_shift             <= {TXW{1'b0}};
            o_bits              <= 5'h0;
            f_ready             <= 1'b0;
            OUT_OVH_ADDR_VALID  <= 1'b0;
            OUT_OVH_ADDR_SERIAL <= 1'b0;
            OUT_OVH_DATA_VALID  <= 1'b0;
            OUT_OVH_DATA_SERIAL <= 1'b0;
        end else begin
            f_ready <= 1'b0;
            if (fall_ev[0]) begin
                case (o_state)
                    ST_IDLE, ST_DATA: begin
                        if (o_state == ST_DATA && o_bits != 5'h1) begin
                            o_bits              <= o_bits - 5'h1;
                            o_shift             <= {o_shift[TXW-2:0], 1'b0};
                            OUT_OVH_DATA_SERIAL <= o_shift[TXW-2];
                        end else if (f_valid && !f_ready) begin
                            f_ready             <= 1'b1;
                            o_state             <= ST_ADDR;
                            o_shift             <= f_data;
                            o_bits              <= `OAP_ADDR_LEN;
                            OUT_OVH_DATA_VALID  <= 1'b0;
                            OUT_OVH_ADDR_VALID  <= 1'b1;
                            OUT_OVH_ADDR_SERIAL <= f_data[TXW-1];
                        end else begin
                            o_state             <= ST_IDLE;
                            OUT_OVH_DATA_VALID  <= 1'b0;
                            OUT_OVH_DATA_SERIAL <= 1'b0;
                        end
                    end
                    ST_ADDR: begin
                        o_shift <= {o_shift[TXW-2:0], 1'b0};
                        if (o_bits != 5'h1) begin
                            o_bits              <= o_bits - 5'h1;
                            OUT_OVH_ADDR_SERIAL <= o_shift[TXW-2];
                        end else begin
                            o_state             <= ST_DATA;
                            o_bits              <= `OAP_DATA_LEN;
                            OUT_OVH_ADDR_VALID  <= 1'b0;
                            OUT_OVH_ADDR_SERIAL <= 1'b0;
                            OUT_OVH_DATA_VALID  <= 1'b1;
                            OUT_OVH_DATA_SERIAL <= o_shift[TXW-2];
                        end
                    end
                    default: begin
                        o_state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input side request holder and sequencer
    reg [3:0]                rq_state;
    reg                      rq_held;
    reg [`OAP_ADDR_BITS-1:0] rq_addr;
    reg [`OAP_ADDR_BITS-1:0] i_shift;
    reg [3:0]                i_bits;
    reg [1:0]                i_rises;
    reg [3:0]                i_samples;
    reg [`OAP_DATA_BITS-1:0] i_byte;
    wire                     rq_is_v5;

    assign rq_is_v5 = (rq_addr[`OAP_ITEM_BITS-1:0] == `OAP_ITEM_V5);

    always @(posedge CORE_CLK) begin
        if (!NRST) begin
            rq_state           <= ST_IDLE;
            rq_held            <= 1'b0;
            rq_addr            <= {`OAP_ADDR_BITS{1'b0}};
            RQ_READY           <= 1'b0;
            i_shift            <= {`OAP_ADDR_BITS{1'b0}};
            i_bits             <= `OAP_CNT_ZERO;
            i_rises            <= 2'h0;
            i_samples          <= `OAP_CNT_ZERO;
            i_byte             <= {`OAP_DATA_BITS{1'b0}};
            RX_VALID           <= 1'b0;
            RX_ADDR            <= {`OAP_ADDR_BITS{1'b0}};
            RX_BYTE            <= {`OAP_DATA_BITS{1'b0}};
            IN_OVH_ADDR_VALID  <= 1'b0;
            IN_OVH_ADDR_SERIAL <= 1'b0;
            IN_OVH_DATA_VALID  <= 1'b0;
        end else begin
            RX_VALID <= 1'b0;
            RQ_READY <= !rq_held && !(RQ_VALID && RQ_READY);
            if (RQ_VALID && RQ_READY) begin
                rq_held <= 1'b1;
                rq_addr <= {RQ_CHANNEL, RQ_ITEM};
            end else if (rq_held && rq_is_v5) begin
                rq_held <= 1'b0;
            end
            // Sampling on the input port clock rising edge
            if (rise_ev[1] && (rq_state == ST_DATA || rq_state == ST_TAIL)) begin
                if (i_rises != `OAP_RISE_LATER) begin
                    i_rises <= i_rises + 2'h1;
                end
                if (i_rises != `OAP_RISE_FIRST && i_rises != `OAP_RISE_LATER) begin
                    i_samples <= `OAP_CNT_ZERO;
                end else begin
                    i_byte    <= {i_byte[`OAP_DATA_BITS-2:0], din_s2};
                    i_samples <= i_samples + `OAP_CNT_ONE;
                    if (i_samples == `OAP_DATA_BITS - 1) begin
                        RX_VALID <= 1'b1;
                        RX_ADDR  <= i_shift;
                        RX_BYTE  <= {i_byte[`OAP_DATA_BITS-2:0], din_s2};
                        rq_state <= ST_IDLE;
                    end
                end
            end else if (fall_ev[1]) begin
                case (rq_state)
                    ST_IDLE: begin
                        if (rq_held && !rq_is_v5) begin
                            rq_held            <= 1'b0;
                            rq_state           <= ST_ADDR;
                            i_shift            <= rq_addr;
                            i_bits             <= `OAP_ADDR_LAST;
                            IN_OVH_ADDR_VALID  <= 1'b1;
                            IN_OVH_ADDR_SERIAL <= rq_addr[`OAP_ADDR_BITS-1];
                        end
                    end
                    ST_ADDR: begin
                        if (i_bits != `OAP_CNT_ZERO) begin
                            i_bits             <= i_bits - `OAP_CNT_ONE;
                            IN_OVH_ADDR_SERIAL <= i_shift[i_bits - `OAP_CNT_ONE];
                        end else begin
                            rq_state           <= ST_DATA;
                            i_bits             <= `OAP_DATA_LAST;
                            i_rises            <= 2'h0;
                            i_samples          <= `OAP_CNT_ZERO;
                            IN_OVH_ADDR_VALID  <= 1'b0;
                            IN_OVH_ADDR_SERIAL <= 1'b0;
                            IN_OVH_DATA_VALID  <= 1'b1;
                        end
                    end
                    ST_DATA: begin
                        if (i_bits != `OAP_CNT_ZERO) begin
                            i_bits <= i_bits - `OAP_CNT_ONE;
                        end else begin
                            rq_state          <= ST_TAIL;
                            IN_OVH_DATA_VALID <= 1'b0;
                        end
                    end
                    ST_TAIL: begin
                        rq_state <= ST_TAIL;
                    end
                    default: begin
                        rq_state <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// ---- design/oap_defs.vh ----
// Purpose: Constants of the overhead auxiliary serial port.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef OAP_DEFS_VH
`define OAP_DEFS_VH

// Field lengths on the serial lines
`define OAP_ADDR_BITS   12
`define OAP_DATA_BITS   8
`define OAP_ITEM_BITS   3

// Overhead item codes, low subfield of the serial address
`define OAP_ITEM_OBITS  3'h0
`define OAP_ITEM_V5     3'h1
`define OAP_ITEM_J2     3'h2
`define OAP_ITEM_Z6N2   3'h3
`define OAP_ITEM_Z7K4   3'h4

// Port clock half period in bus clock rising edges
`define OAP_HALF_DIV2   2'h1
`define OAP_HALF_DIV4   2'h2

// Bit counter constants
`define OAP_CNT_ZERO    4'h0
`define OAP_CNT_ONE     4'h1
`define OAP_RISE_FIRST  2'h1
`define OAP_RISE_LATER  2'h2
`define OAP_ADDR_LEN    5'h0C
`define OAP_DATA_LEN    5'h08
`define OAP_ADDR_LAST   4'hB
`define OAP_DATA_LAST   4'h7

`endif

// ---- design/oap_fifo.v ----
// Purpose: Small flop FIFO with valid and ready on both sides.
// Assumes: Single clock, synchronous active low reset.
// Notes:   Full and empty are registered.
`timescale 1ns/1ps
`include "oap_defs.vh"

module oap_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // Clock and reset
    input  wire             clk,
    input  wire             nrst,
    // Fill side
    input  wire             in_valid,
    output reg              in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output reg              out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    reg [AW:0]      next_count;
    wire            push;
    wire            pop;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always @* begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            count     <= next_count;
            in_ready  <= (next_count != DEPTH);
            out_valid <= (next_count != {(AW+1){1'b0}});
        end
    end
endmodule

// ---- testbench/oap_aux_port_properties.sv ----
// Purpose: Port timing checks of the overhead auxiliary serial port.
// Assumes: Bound to oap_aux_port; rate select changes only in reset.
// Notes:   Bit periods counted at port clock fall events.
`timescale 1ns/1ps

module oap_props (
    // Clock, reset, configuration
    input wire CORE_CLK,
    input wire NRST,
    input wire BUS_RATE_SELECT,
    input wire DROP_BUS_CLOCK,
    input wire ADD_BUS_CLOCK,
    // Output port pins
    input wire OUT_OVH_PORT_CLOCK,
    input wire OUT_OVH_ADDR_VALID,
    input wire OUT_OVH_ADDR_SERIAL,
    input wire OUT_OVH_DATA_VALID,
    input wire OUT_OVH_DATA_SERIAL,
    // Input port pins
    input wire IN_OVH_PORT_CLOCK,
    input wire IN_OVH_ADDR_VALID,
    input wire IN_OVH_ADDR_SERIAL,
    input wire IN_OVH_DATA_VALID
);
    wire [3:0] v    = {IN_OVH_DATA_VALID, IN_OVH_ADDR_VALID, OUT_OVH_DATA_VALID, OUT_OVH_ADDR_VALID};
    wire [3:0] op   = {OUT_OVH_ADDR_VALID, OUT_OVH_ADDR_SERIAL, OUT_OVH_DATA_VALID, OUT_OVH_DATA_SERIAL};
    wire [2:0] ip   = {IN_OVH_ADDR_VALID, IN_OVH_ADDR_SERIAL, IN_OVH_DATA_VALID};
    wire [2:0] half = BUS_RATE_SELECT ? 3'h1 : 3'h2;
    reg  [4:0] n [0:3];
    reg  [3:0] p;
    reg  [2:0] c [0:1];
    reg  [1:0] s;
    integer    j;

    ////////////////////////////////////////
    // Strobe lengths in periods, bus clock rises per half period
    always @(posedge CORE_CLK) begin
        for (j = 0; j < 4; j = j + 1) begin
            if (!NRST) begin
                n[j] <= 5'h00;
                p[j] <= 1'b0;
            end else if (j < 2 ? $fell(OUT_OVH_PORT_CLOCK) : $fell(IN_OVH_PORT_CLOCK)) begin
                n[j] <= v[j] ? n[j] + 5'h01 : 5'h00;
                p[j] <= v[j];
            end
        end
        for (j = 0; j < 2; j = j + 1) begin
            if (!NRST) begin
                c[j] <= 3'h0;
                s[j] <= 1'b0;
            end else if (j == 0 ? $changed(OUT_OVH_PORT_CLOCK) : $changed(IN_OVH_PORT_CLOCK)) begin
                c[j] <= 3'h0;
                s[j] <= 1'b1;
            end else if (j == 0 ? $rose(DROP_BUS_CLOCK) : $rose(ADD_BUS_CLOCK)) begin
                c[j] <= c[j] + 3'h1;
            end
        end
    end

    default clocking dc @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);

    AST_OUT_CLK_DIV: assert property ($changed(OUT_OVH_PORT_CLOCK) && s[0] |-> c[0] == half)
        else $error("output port clock divide wrong");
    AST_IN_CLK_DIV: assert property ($changed(IN_OVH_PORT_CLOCK) && s[1] |-> c[1] == half)
        else $error("input port clock divide wrong");
    AST_OUT_AV_LEN: assert property ($fell(OUT_OVH_PORT_CLOCK) && p[0] && !v[0] |-> n[0] == 5'h0C)
        else $error("output address valid length wrong");
    AST_OUT_DV_LEN: assert property ($fell(OUT_OVH_PORT_CLOCK) && p[1] && !v[1] |-> n[1] == 5'h08)
        else $error("output data valid length wrong");
    AST_IN_AV_LEN: assert property ($fell(IN_OVH_PORT_CLOCK) && p[2] && !v[2] |-> n[2] == 5'h0C)
        else $error("input address valid length wrong");
    AST_IN_DV_LEN: assert property ($fell(IN_OVH_PORT_CLOCK) && p[3] && !v[3] |-> n[3] == 5'h08)
        else $error("input data valid length wrong");
    AST_OUT_EDGE: assert property ($changed(op) |-> $fell(OUT_OVH_PORT_CLOCK))
        else $error("output pins moved off port clock fall");
    AST_IN_EDGE: assert property ($changed(ip) |-> $fell(IN_OVH_PORT_CLOCK))
        else $error("input side pins moved off port clock fall");
endmodule

bind oap_aux_port oap_props u_props (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .BUS_RATE_SELECT(BUS_RATE_SELECT),
    .DROP_BUS_CLOCK(DROP_BUS_CLOCK), .ADD_BUS_CLOCK(ADD_BUS_CLOCK),
    .OUT_OVH_PORT_CLOCK(OUT_OVH_PORT_CLOCK), .OUT_OVH_ADDR_VALID(OUT_OVH_ADDR_VALID),
    .OUT_OVH_ADDR_SERIAL(OUT_OVH_ADDR_SERIAL), .OUT_OVH_DATA_VALID(OUT_OVH_DATA_VALID),
    .OUT_OVH_DATA_SERIAL(OUT_OVH_DATA_SERIAL), .IN_OVH_PORT_CLOCK(IN_OVH_PORT_CLOCK),
    .IN_OVH_ADDR_VALID(IN_OVH_ADDR_VALID), .IN_OVH_ADDR_SERIAL(IN_OVH_ADDR_SERIAL),
    .IN_OVH_DATA_VALID(IN_OVH_DATA_VALID)
);

// ---- testbench/oap_far_model.sv ----
// Purpose: Far side overhead logic feeding the input auxiliary port.
// Assumes: Port pins are stable at core clock falls.
// Notes:   Byte sent is low address byte xor 5A; late adds 30 ns.
`timescale 1ns/1ps

module oap_far_model (
    // Clock and behaviour
    input  wire        clk,
    input  wire        late,
    // Port pins
    input  wire        port_clk,
    input  wire        addr_valid,
    input  wire        addr_serial,
    input  wire        data_valid,
    output reg         data_out,
    output reg  [11:0] last_addr
);
    reg       pck = 1'b0;
    reg       dv_q = 1'b0;
    reg [3:0] left = 4'h0;
    reg [7:0] shift = 8'h00;

    ////////////////////////////////////////
    initial begin
        data_out = 1'b0;
        last_addr = 12'h000;
    end
    always @(negedge clk) begin
        pck <= port_clk;
        if (!pck && port_clk && addr_valid)
            last_addr <= {last_addr[10:0], addr_serial};
        if (pck && !port_clk) begin
            dv_q <= data_valid;
            if (data_valid && !dv_q) begin
                shift <= last_addr[7:0] ^ 8'h5A;
                left <= 4'h8;
            end else if (left != 4'h0) begin
                // Bit stands from this fall past the sampling rise
                data_out <= #(late ? 30 : 0) shift[7];
                shift <= {shift[6:0], 1'b0};
                left <= left - 4'h1;
            end else begin
                // Released line: no stale value
                data_out <= ~data_out;
            end
        end
    end
endmodule

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench of the overhead auxiliary serial port.
// Assumes: Bus clocks 160 ns and 170 ns, unrelated to the core clock.
// Notes:   Both rate selections; export fills the buffer until refused.
`timescale 1ns/1ps
`include "oap_defs.vh"
`define CHK(nm, ex, gt) begin check_count = check_count + 1; if ((gt) !== (ex)) begin \
    fail_count = fail_count + 1; $display("ERROR %s expected %h seen %h", nm, ex, gt); end end

module tb;
    reg         CORE_CLK, NRST, BUS_RATE_SELECT, DROP_BUS_CLOCK, ADD_BUS_CLOCK;
    reg         TX_VALID, RQ_VALID, late;
    reg  [8:0]  TX_CHANNEL, RQ_CHANNEL;
    reg  [2:0]  TX_ITEM, RQ_ITEM;
    reg  [7:0]  TX_BYTE;
    wire        TX_READY, RQ_READY, RX_VALID;
    wire [11:0] RX_ADDR, far_addr;
    wire [7:0]  RX_BYTE;
    wire        ock, oav, oas, odv, ods, ick, iav, ias, idv, ids;
    integer     fail_count, check_count;
    reg  [19:0] mq [$];
    reg  [11:0] m_addr;
    reg  [7:0]  m_data;
    reg  [3:0]  m_n;
    reg         m_ck;

    oap_aux_port DUT (
        .CORE_CLK(CORE_CLK), .NRST(NRST), .BUS_RATE_SELECT(BUS_RATE_SELECT),
        .DROP_BUS_CLOCK(DROP_BUS_CLOCK), .ADD_BUS_CLOCK(ADD_BUS_CLOCK),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_CHANNEL(TX_CHANNEL), .TX_ITEM(TX_ITEM),
        .TX_BYTE(TX_BYTE), .RQ_VALID(RQ_VALID), .RQ_READY(RQ_READY), .RQ_CHANNEL(RQ_CHANNEL),
        .RQ_ITEM(RQ_ITEM), .RX_VALID(RX_VALID), .RX_ADDR(RX_ADDR), .RX_BYTE(RX_BYTE),
        .OUT_OVH_PORT_CLOCK(ock), .OUT_OVH_ADDR_VALID(oav), .OUT_OVH_ADDR_SERIAL(oas),
        .OUT_OVH_DATA_VALID(odv), .OUT_OVH_DATA_SERIAL(ods), .IN_OVH_PORT_CLOCK(ick),
        .IN_OVH_ADDR_VALID(iav), .IN_OVH_ADDR_SERIAL(ias), .IN_OVH_DATA_VALID(idv),
        .IN_OVH_DATA_SERIAL(ids)
    );
    oap_far_model u_far (
        .clk(CORE_CLK), .late(late), .port_clk(ick), .addr_valid(iav),
        .addr_serial(ias), .data_valid(idv), .data_out(ids), .last_addr(far_addr)
    );

    ////////////////////////////////////////
    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    initial begin
        DROP_BUS_CLOCK = 1'b0;
        forever #80 DROP_BUS_CLOCK = ~DROP_BUS_CLOCK;
    end
    initial begin
        ADD_BUS_CLOCK = 1'b0;
        #23;
        forever #85 ADD_BUS_CLOCK = ~ADD_BUS_CLOCK;
    end

    // Output port frames decoded at port clock rise
    always @(negedge CORE_CLK) begin
        if (!NRST)
            m_n = 4'h0;
        if (!m_ck && ock && oav)
            m_addr = {m_addr[10:0], oas};
        if (!m_ck && ock && odv) begin
            m_data = {m_data[6:0], ods};
            m_n = m_n + 4'h1;
            if (m_n == 4'h8) begin
                mq.push_back({m_addr, m_data});
                m_n = 4'h0;
            end
        end
        m_ck = ock;
    end

    task do_reset(input reg rate);
        begin
            NRST = 1'b0;
            BUS_RATE_SELECT = rate;
            repeat (20) @(negedge CORE_CLK);
            `CHK("reset_port_clock", 1'b0, ock)
            `CHK("reset_tx_ready", 1'b0, TX_READY)
            NRST = 1'b1;
            repeat (2) @(negedge CORE_CLK);
        end
    endtask

    task t_export;
        integer    i;
        integer    k;
        reg        full;
        reg [19:0] ex;
        begin
            full = 1'b0;
            mq.delete();
            for (i = 0; i < 6; i = i + 1) begin
                TX_VALID = 1'b1;
                TX_CHANNEL = 9'h0A0 | i[8:0];
                TX_ITEM = (i == 5) ? `OAP_ITEM_OBITS : i[2:0];
                TX_BYTE = 8'hC3 ^ i[7:0];
                while (TX_READY !== 1'b1) begin
                    full = 1'b1;
                    @(negedge CORE_CLK);
                end
                @(negedge CORE_CLK);
            end
            TX_VALID = 1'b0;
            for (k = 0; k < 20000 && mq.size() < 6; k = k + 1)
                @(negedge CORE_CLK);
            `CHK("tx_refused_when_full", 1'b1, full)
            for (i = 0; i < 6; i = i + 1) begin
                ex = {9'h0A0 | i[8:0], (i == 5) ? 3'h0 : i[2:0], 8'hC3 ^ i[7:0]};
                `CHK("out_frame", ex, (i < mq.size()) ? mq[i] : 20'hX_XXXX)
            end
        end
    endtask

    task t_import(input reg lt);
        integer    i;
        integer    k;
        reg [2:0]  it;
        reg [11:0] ea;
        reg        got;
        reg        seen;
        begin
            late = lt;
            for (i = 0; i < 5; i = i + 1) begin
                it = (i == 4) ? `OAP_ITEM_V5 : ((i == 0) ? `OAP_ITEM_OBITS : i[2:0] + 3'h1);
                ea = {9'h150 | i[8:0], it};
                RQ_VALID = 1'b1;
                RQ_CHANNEL = ea[11:3];
                RQ_ITEM = it;
                while (RQ_READY !== 1'b1)
                    @(negedge CORE_CLK);
                @(negedge CORE_CLK);
                RQ_VALID = 1'b0;
                got = 1'b0;
                seen = 1'b0;
                for (k = 0; k < 4000 && !got; k = k + 1) begin
                    @(negedge CORE_CLK);
                    got = (RX_VALID === 1'b1);
                    seen = seen | (iav === 1'b1);
                end
                if (it == `OAP_ITEM_V5) begin
                    `CHK("v5_not_requested", 2'b00, {got, seen})
                end else begin
                    `CHK("rx_valid", 1'b1, got)
                    `CHK("wire_addr", ea, far_addr)
                    `CHK("rx_addr", ea, RX_ADDR)
                    `CHK("rx_byte", ea[7:0] ^ 8'h5A, RX_BYTE)
                end
            end
        end
    endtask

    task test_done;
        begin
            $display("checks %0d mismatches %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    initial begin
        #700000;
        fail_count = fail_count + 1;
        test_done;
    end

    initial begin
        fail_count = 0;
        check_count = 0;
        NRST = 1'b0;
        BUS_RATE_SELECT = 1'b1;
        {TX_VALID, RQ_VALID, late, TX_ITEM, RQ_ITEM} = 9'h000;
        {TX_CHANNEL, RQ_CHANNEL, TX_BYTE} = 26'h000_0000;
        do_reset(1'b1);
        t_export;
        t_import(1'b0);
        do_reset(1'b0);
        t_export;
        t_import(1'b1);
        test_done;
    end
endmodule
